/* File: include/ccb_pkg.sv */
package ccb_pkg;

  // ------------------------------------------------------------
  // Operation codes handed over by the instruction decoder
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_PUSH_A, OP_PUSH_AH, OP_PUSH_PS, OP_PUSH_LIST,
    OP_POP_A, OP_POP_AH, OP_POP_PS, OP_POP_LIST,
    OP_AND_CCR, OP_OR_CCR, OP_MOV_RP, OP_MOV_ILM,
    OP_EFFECTIVE_ADDRESS_MOVE_RW, OP_EFFECTIVE_ADDRESS_MOVE_A, OP_MOV_A_BANK,
    OP_PFX_ADB, OP_PFX_DTB, OP_PFX_PCB, OP_PFX_SPB, OP_PFX_NCC, OP_PFX_CMR,
    OP_LIM_UPPER, OP_LIM_LOWER, OP_CHECK_ON, OP_CHECK_OFF,
    OP_SCAN, OP_SCAN_X2, OP_SCAN_X4,
    OP_BIT_TO_A, OP_A_TO_BIT, OP_BIT_SET, OP_BIT_CLR,
    OP_BR_CLEAR, OP_BR_SET, OP_TEST_SET_BR, OP_WAIT_HIGH, OP_WAIT_LOW
  } ccb_op_t;

  // Bank register selected by a bank-to-accumulator move.
  typedef enum logic [2:0] {
    BANK_PCB, BANK_ADB, BANK_SSB, BANK_USB, BANK_SPB, BANK_DTB, BANK_DPR
  } ccb_bank_t;

  // ------------------------------------------------------------
  // Access space codes, field positions, stack step
  // ------------------------------------------------------------
  localparam logic [2:0] SPACE_DEF = 3'h0;
  localparam logic [2:0] SPACE_ADB = 3'h1;
  localparam logic [2:0] SPACE_DTB = 3'h2;
  localparam logic [2:0] SPACE_PCB = 3'h3;
  localparam logic [2:0] SPACE_SPB = 3'h4;
  localparam int CCR_I = 6;
  localparam int CCR_S = 5;
  localparam int CCR_T = 4;
  localparam int CCR_N = 3;
  localparam int CCR_Z = 2;
  localparam int CCR_V = 1;
  localparam int CCR_C = 0;
  localparam int PS_ILM_LSB = 13;
  localparam int PS_RP_LSB = 8;
  localparam logic [15:0] STACK_STEP = 16'h0002;

  // ------------------------------------------------------------
  // Cycle counts
  // ------------------------------------------------------------
  localparam logic [5:0] CYC_STACK = 6'h03;
  localparam logic [5:0] CYC_LIST_BASE = 6'h03;
  localparam logic [5:0] CYC_LIST_PER = 6'h04;
  localparam logic [5:0] CYC_CCR = 6'h03;
  localparam logic [5:0] CYC_IMM8 = 6'h02;
  localparam logic [5:0] CYC_EA_RW_REG = 6'h03;
  localparam logic [5:0] CYC_EA_RW_MEM = 6'h02;
  localparam logic [5:0] CYC_EA_A_REG = 6'h02;
  localparam logic [5:0] CYC_EA_A_MEM = 6'h01;
  localparam logic [5:0] CYC_BANK_FAST = 6'h01;
  localparam logic [5:0] CYC_BANK_DTB = 6'h02;
  localparam logic [5:0] CYC_BANK_DPR = 6'h03;
  localparam logic [5:0] CYC_PREFIX = 6'h01;
  localparam logic [5:0] CYC_CHECK = 6'h02;
  localparam logic [5:0] CYC_SCAN_ZERO = 6'h03;
  localparam logic [5:0] CYC_SCAN_SET = 6'h05;
  localparam logic [5:0] CYC_BIT_READ = 6'h03;
  localparam logic [5:0] CYC_RMW = 6'h04;
  localparam logic [5:0] CYC_BR_TAKEN = 6'h05;
  localparam logic [5:0] CYC_BR_NOT = 6'h04;
  localparam logic [5:0] CYC_TSB_TAKEN = 6'h07;
  localparam logic [5:0] CYC_TSB_NOT = 6'h06;
  localparam logic [5:0] CYC_WAIT_HOLD = 6'h02;
  localparam logic [5:0] CYC_NEVER = 6'h3f;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    ccb_op_t op;
    logic [15:0] imm;
    logic [7:0] list;
    logic [15:0] addr;
    logic [2:0] bp;
    logic [2:0] ridx;
    logic ea_reg;
    ccb_bank_t bank;
  } ccb_instr_t;

  typedef struct packed {
    logic req;
    logic we;
    logic byte_acc;
    logic [2:0] space;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ccb_mem_t;

  typedef struct packed {
    logic we;
    logic [2:0] idx;
    logic [15:0] wdata;
  } ccb_rw_t;

  typedef struct packed {
    logic [2:0] space;
    logic no_flag_change_prefix;
    logic common_bank_prefix;
  } ccb_pfx_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic branch;
    logic taken;
    logic [5:0] cnt;
    logic [5:0] tot;
    ccb_instr_t ins;
    logic [7:0] list;
    logic [31:0] acc;
    logic [15:0] sp;
    logic [2:0] interrupt_level_mask;
    logic [4:0] rp;
    logic [6:0] condition_code_byte;
    logic [15:0] lim_up;
    logic [15:0] lim_lo;
    logic chk_en;
    logic fault;
    ccb_pfx_t pfx;
    ccb_pfx_t cur;
    ccb_mem_t mem;
    ccb_rw_t rw;
  } ccb_state_t;

  localparam ccb_state_t STATE_RST = '0;

endpackage

/* File: src/ccb_exec.sv */
`timescale 1ns/1ps
// Functional notes
// - Single push: stack pointer minus two, store, 3 cycles.
// - List push: two per register, 3+4n cycles.
// - Single pop: load, stack pointer plus two; status restores.
// - List pop restores each register, 3+4n cycles.
// - AND/OR immediate into condition byte, 3 cycles.
// - Bank pointer, level mask immediate loads, 2 cycles.
// - Effective address itself goes to destination, flags kept.
// - Bank move costs 1, 2 or 3 cycles.
// - One-cycle prefixes select bank space for next access.
// - One-cycle prefix suppresses flag updates of next instruction.
// - One-cycle prefix selects common register bank next.
// - Stack limit registers load 16-bit immediate, 2 cycles.
// - Two-cycle instructions enable, disable stack limit checking.
// - Scan writes set-bit position, optionally times two/four.
// - Bit read into accumulator, flags N Z, 3 cycles.
// - Accumulator into bit by read-modify-write, 4 cycles.
// - Bit set by read-modify-write, 4 cycles, flags kept.
// - Bit clear by read-modify-write, 4 cycles, flags kept.
// - Bit branches set Z; 5 taken, 4 not.
// - Test-and-set branch leaves bit set; 7 or 6 cycles.
// - Wait instructions stall until I/O bit matches.
module ccb_exec (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire ccb_pkg::ccb_instr_t instr,
  input wire logic [15:0] ea,
  input wire logic [7:0] bank_rdata,
  input wire logic [15:0] rw_rdata,
  input wire logic [15:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic branch,
  output ccb_pkg::ccb_mem_t mem,
  output ccb_pkg::ccb_rw_t rw,
  output logic [31:0] acc,
  output logic [15:0] sp,
  output logic [15:0] ps,
  output logic [15:0] stack_limit_upper,
  output logic [15:0] stack_limit_lower,
  output logic stack_check_en,
  output logic stack_fault,
  output logic [2:0] access_space,
  output logic common_bank_sel
);
  import ccb_pkg::*;

  ccb_state_t s_q;
  ccb_state_t s_d;
  logic [7:0] list_vec;
  logic [2:0] pick_raw;
  logic [2:0] pick;
  logic pick_any;
  logic [3:0] scan_pos;
  logic scan_any;
  logic is_pop_list;

  // ------------------------------------------------------------
  // Register list walk and bit scan
  // ------------------------------------------------------------
  // Pushes take the lowest register first, so pops must take the highest first.
  assign is_pop_list = (s_q.ins.op == OP_POP_LIST);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      list_vec[i] = is_pop_list ? s_q.list[7 - i] : s_q.list[i];
    end
  end
  assign pick = is_pop_list ? 3'(3'h7 - pick_raw) : pick_raw;

  ccb_lowbit #(.W(8), .IW(3)) u_list (.vec(list_vec), .idx(pick_raw), .any(pick_any));
  ccb_lowbit #(.W(16), .IW(4)) u_scan (.vec(s_q.acc[15:0]), .idx(scan_pos), .any(scan_any));

  // ------------------------------------------------------------
  // Execution sequencer
  // ------------------------------------------------------------
  // One pass through this process decides the next step of the running instruction.
  always_comb begin
    logic [3:0] n;
    logic bitv;
    logic hit;
    logic [7:0] byte_new;
    logic [7:0] pos;
    logic first;
    logic second;
    logic slot;
    logic slot_wr;
    n = 4'h0;
    bitv = 1'b0;
    hit = 1'b0;
    byte_new = 8'h00;
    pos = 8'h00;
    first = (s_q.cnt == 6'h01);
    second = (s_q.cnt == 6'h02);
    slot = (s_q.cnt >= 6'h03) && (s_q.cnt[1:0] == 2'b11);
    slot_wr = (s_q.cnt >= 6'h04) && (s_q.cnt[1:0] == 2'b00);
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.branch = 1'b0;
    s_d.mem.req = 1'b0;
    s_d.mem.we = 1'b0;
    s_d.rw.we = 1'b0;
    for (int i = 0; i < 8; i++) begin
      n = n + 4'(instr.list[i]);
    end
    bitv = mem_rdata[s_q.ins.bp];
    byte_new = mem_rdata[7:0];
    // Limits are compared every cycle; a violation shows one cycle after it exists, as the fault is registered.
    s_d.fault = s_q.chk_en && ((s_q.sp > s_q.lim_up) || (s_q.sp < s_q.lim_lo));
    if (!s_q.busy) begin
      if (start) begin
        s_d.busy = 1'b1;
        s_d.cnt = 6'h01;
        s_d.ins = instr;
        s_d.list = instr.list;
        s_d.taken = 1'b0;
        unique case (instr.op)
          OP_PUSH_A, OP_PUSH_AH, OP_PUSH_PS, OP_POP_A, OP_POP_AH, OP_POP_PS:
            s_d.tot = CYC_STACK;
          OP_PUSH_LIST, OP_POP_LIST:
            s_d.tot = CYC_LIST_BASE + 6'(n) * CYC_LIST_PER;
          OP_AND_CCR, OP_OR_CCR: s_d.tot = CYC_CCR;
          OP_MOV_RP, OP_MOV_ILM: s_d.tot = CYC_IMM8;
          OP_EFFECTIVE_ADDRESS_MOVE_RW: s_d.tot = instr.ea_reg ? CYC_EA_RW_REG : CYC_EA_RW_MEM;
          OP_EFFECTIVE_ADDRESS_MOVE_A: s_d.tot = instr.ea_reg ? CYC_EA_A_REG : CYC_EA_A_MEM;
          OP_MOV_A_BANK: begin
            s_d.tot = (instr.bank == BANK_DTB) ? CYC_BANK_DTB :
                      (instr.bank == BANK_DPR) ? CYC_BANK_DPR : CYC_BANK_FAST;
          end
          OP_PFX_ADB, OP_PFX_DTB, OP_PFX_PCB, OP_PFX_SPB, OP_PFX_NCC, OP_PFX_CMR:
            s_d.tot = CYC_PREFIX;
          OP_LIM_UPPER, OP_LIM_LOWER, OP_CHECK_ON, OP_CHECK_OFF:
            s_d.tot = CYC_CHECK;
          OP_SCAN: s_d.tot = scan_any ? CYC_SCAN_SET : CYC_SCAN_ZERO;
          OP_SCAN_X2: s_d.tot = 6'((scan_any ? CYC_SCAN_SET : CYC_SCAN_ZERO) + 6'h01);
          OP_SCAN_X4: s_d.tot = 6'((scan_any ? CYC_SCAN_SET : CYC_SCAN_ZERO) + 6'h02);
          OP_BIT_TO_A: s_d.tot = CYC_BIT_READ;
          OP_A_TO_BIT, OP_BIT_SET, OP_BIT_CLR: s_d.tot = CYC_RMW;
          OP_BR_CLEAR, OP_BR_SET: s_d.tot = CYC_BR_NOT;
          OP_TEST_SET_BR: s_d.tot = CYC_TSB_NOT;
          OP_WAIT_HIGH, OP_WAIT_LOW: s_d.tot = CYC_NEVER;
        endcase
        // A prefix only records itself; any other instruction consumes what is pending.
        unique case (instr.op)
          OP_PFX_ADB: s_d.pfx.space = SPACE_ADB;
          OP_PFX_DTB: s_d.pfx.space = SPACE_DTB;
          OP_PFX_PCB: s_d.pfx.space = SPACE_PCB;
          OP_PFX_SPB: s_d.pfx.space = SPACE_SPB;
          OP_PFX_NCC: s_d.pfx.no_flag_change_prefix = 1'b1;
          OP_PFX_CMR: s_d.pfx.common_bank_prefix = 1'b1;
          default: begin
            s_d.cur = s_q.pfx;
            s_d.pfx = '0;
          end
        endcase
      end
    end else begin
      s_d.cnt = 6'(s_q.cnt + 6'h01);
      if (s_q.cnt == s_q.tot) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.branch = s_q.taken;
        s_d.cur = '0;
      end
      s_d.mem.space = s_q.cur.space;
      s_d.mem.byte_acc = 1'b0;
      unique case (s_q.ins.op)
        OP_PUSH_A, OP_PUSH_AH, OP_PUSH_PS: begin
          if (first) begin
            s_d.sp = s_q.sp - STACK_STEP;
            s_d.mem = '{1'b1, 1'b1, 1'b0, SPACE_SPB, s_q.sp - STACK_STEP, 16'h0000};
            s_d.mem.wdata = (s_q.ins.op == OP_PUSH_A) ? s_q.acc[15:0] :
                            (s_q.ins.op == OP_PUSH_AH) ? s_q.acc[31:16] : ps;
          end
        end
        OP_PUSH_LIST: begin
          if (slot && pick_any) begin
            s_d.rw.idx = pick;
            s_d.list[pick] = 1'b0;
          end
          if (slot_wr) begin
            s_d.sp = s_q.sp - STACK_STEP;
            s_d.mem = '{1'b1, 1'b1, 1'b0, SPACE_SPB, s_q.sp - STACK_STEP, rw_rdata};
          end
        end
        OP_POP_A, OP_POP_AH, OP_POP_PS: begin
          if (first) begin
            s_d.mem = '{1'b1, 1'b0, 1'b0, SPACE_SPB, s_q.sp, 16'h0000};
          end
          if (second) begin
            s_d.sp = s_q.sp + STACK_STEP;
            if (s_q.ins.op == OP_POP_A) begin
              s_d.acc = {s_q.acc[15:0], mem_rdata};
            end else if (s_q.ins.op == OP_POP_AH) begin
              s_d.acc[31:16] = mem_rdata;
            end else begin
              s_d.interrupt_level_mask = mem_rdata[PS_ILM_LSB +: 3];
              s_d.rp = mem_rdata[PS_RP_LSB +: 5];
              s_d.condition_code_byte = mem_rdata[6:0];
            end
          end
        end
        OP_POP_LIST: begin
          if (slot && pick_any) begin
            s_d.rw.idx = pick;
            s_d.list[pick] = 1'b0;
            s_d.mem = '{1'b1, 1'b0, 1'b0, SPACE_SPB, s_q.sp, 16'h0000};
          end
          if (slot_wr) begin
            s_d.sp = s_q.sp + STACK_STEP;
            s_d.rw.we = 1'b1;
            s_d.rw.wdata = mem_rdata;
          end
        end
        OP_AND_CCR: if (first) s_d.condition_code_byte = s_q.condition_code_byte & s_q.ins.imm[6:0];
        OP_OR_CCR: if (first) s_d.condition_code_byte = s_q.condition_code_byte | s_q.ins.imm[6:0];
        OP_MOV_RP: if (first) s_d.rp = s_q.ins.imm[4:0];
        OP_MOV_ILM: if (first) s_d.interrupt_level_mask = s_q.ins.imm[2:0];
        OP_EFFECTIVE_ADDRESS_MOVE_RW: begin
          if (first) begin
            s_d.rw = '{1'b1, s_q.ins.ridx, ea};
          end
        end
        OP_EFFECTIVE_ADDRESS_MOVE_A: if (first) s_d.acc[15:0] = ea;
        OP_MOV_A_BANK: begin
          if (first) begin
            s_d.acc[15:0] = {8'h00, bank_rdata};
            if (!s_q.cur.no_flag_change_prefix) begin
              s_d.condition_code_byte[CCR_N] = bank_rdata[7];
              s_d.condition_code_byte[CCR_Z] = (bank_rdata == 8'h00);
            end
          end
        end
        OP_PFX_ADB, OP_PFX_DTB, OP_PFX_PCB, OP_PFX_SPB, OP_PFX_NCC, OP_PFX_CMR: ;
        OP_LIM_UPPER: if (first) s_d.lim_up = s_q.ins.imm;
        OP_LIM_LOWER: if (first) s_d.lim_lo = s_q.ins.imm;
        OP_CHECK_ON: if (first) s_d.chk_en = 1'b1;
        OP_CHECK_OFF: if (first) s_d.chk_en = 1'b0;
        OP_SCAN, OP_SCAN_X2, OP_SCAN_X4: begin
          if (first) begin
            pos = {4'h0, scan_pos};
            if (s_q.ins.op == OP_SCAN_X2) pos = {3'h0, scan_pos, 1'b0};
            if (s_q.ins.op == OP_SCAN_X4) pos = {2'h0, scan_pos, 2'b00};
            s_d.acc[15:0] = {8'h00, pos};
            if (!s_q.cur.no_flag_change_prefix) s_d.condition_code_byte[CCR_Z] = !scan_any;
          end
        end
        OP_WAIT_HIGH, OP_WAIT_LOW: begin
          hit = (s_q.ins.op == OP_WAIT_HIGH) ? bitv : !bitv;
          s_d.mem = '{1'b1, 1'b0, 1'b1, s_q.cur.space, s_q.ins.addr, 16'h0000};
          s_d.cnt = CYC_WAIT_HOLD;
          // The read repeats every cycle; nothing bounds how long the bit takes.
          if (second && hit) begin
            s_d.mem.req = 1'b0;
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.cur = '0;
          end
        end
        default: begin
          // All remaining operations read one byte, then act on the addressed bit.
          if (first) begin
            s_d.mem = '{1'b1, 1'b0, 1'b1, s_q.cur.space, s_q.ins.addr, 16'h0000};
          end
          if (second) begin
            unique case (s_q.ins.op)
              OP_BIT_TO_A: begin
                s_d.acc[15:0] = {8'h00, {8{bitv}}};
                hit = 1'b0;
              end
              OP_A_TO_BIT: hit = 1'b1;
              OP_BIT_SET, OP_BIT_CLR: hit = 1'b1;
              OP_BR_CLEAR: begin
                s_d.taken = !bitv;
                s_d.tot = bitv ? CYC_BR_NOT : CYC_BR_TAKEN;
              end
              OP_BR_SET: begin
                s_d.taken = bitv;
                s_d.tot = bitv ? CYC_BR_TAKEN : CYC_BR_NOT;
              end
              default: begin
                s_d.taken = bitv;
                s_d.tot = bitv ? CYC_TSB_TAKEN : CYC_TSB_NOT;
                hit = 1'b1;
              end
            endcase
            byte_new[s_q.ins.bp] = (s_q.ins.op == OP_BIT_CLR) ? 1'b0 :
                                   (s_q.ins.op == OP_A_TO_BIT) ? (s_q.acc[7:0] != 8'h00) :
                                   1'b1;
            if (hit) begin
              s_d.mem = '{1'b1, 1'b1, 1'b1, s_q.cur.space, s_q.ins.addr, {8'h00, byte_new}};
            end
            // Flag updates: only the moves and the branches touch N or Z.
            if (!s_q.cur.no_flag_change_prefix) begin
              if (s_q.ins.op == OP_BIT_TO_A) begin
                s_d.condition_code_byte[CCR_N] = bitv;
                s_d.condition_code_byte[CCR_Z] = !bitv;
              end else if (s_q.ins.op == OP_A_TO_BIT) begin
                s_d.condition_code_byte[CCR_N] = s_q.acc[7];
                s_d.condition_code_byte[CCR_Z] = (s_q.acc[7:0] == 8'h00);
              end else if (s_q.ins.op != OP_BIT_SET && s_q.ins.op != OP_BIT_CLR) begin
                s_d.condition_code_byte[CCR_Z] = !bitv;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign busy = s_q.busy;
  assign done = s_q.done;
  assign branch = s_q.branch;
  assign mem = s_q.mem;
  assign rw = s_q.rw;
  assign acc = s_q.acc;
  assign sp = s_q.sp;
  assign ps = {s_q.interrupt_level_mask, s_q.rp, 1'b0, s_q.condition_code_byte};
  assign stack_limit_upper = s_q.lim_up;
  assign stack_limit_lower = s_q.lim_lo;
  assign stack_check_en = s_q.chk_en;
  assign stack_fault = s_q.fault;
  assign access_space = s_q.cur.space;
  assign common_bank_sel = s_q.cur.common_bank_prefix;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic go;
  assign go = start && !s_q.busy;
  sequence rmw_read;
    mem.req && !mem.we && mem.byte_acc;
  endsequence
  sequence rmw_write;
    mem.req && mem.we && mem.byte_acc;
  endsequence

  push_sp_a: assert property (go && instr.op == OP_PUSH_A |-> ##2
    (sp == $past(sp, 2) - STACK_STEP) && mem.we ##2 done)
    else $error("single push did not lower the stack pointer in time");
  pop_sp_a: assert property (go && instr.op == OP_POP_A |-> ##3
    (sp == $past(sp, 3) + STACK_STEP) ##1 done)
    else $error("single pop did not raise the stack pointer in time");
  ccr_and_a: assert property (go && instr.op == OP_AND_CCR |-> ##2
    ccr_match(ps[6:0], $past(ps[6:0], 2) & $past(instr.imm[6:0], 2)) ##2 done)
    else $error("condition byte AND result wrong");
  rp_load_a: assert property (go && instr.op == OP_MOV_RP |-> ##2
    (ps[12:8] == $past(instr.imm[4:0], 2)) ##1 done)
    else $error("bank pointer load wrong");
  bank_dpr_a: assert property (go && instr.op == OP_MOV_A_BANK &&
    instr.bank == BANK_DPR |-> ##1 !done [*3] ##1 done)
    else $error("direct page move cycle count wrong");
  scan_time_a: assert property (go && instr.op == OP_SCAN_X4 &&
    acc[15:0] != 16'h0000 |-> ##1 busy [*7] ##1 done)
    else $error("scaled scan cycle count wrong");
  bit_set_a: assert property (go && instr.op == OP_BIT_SET |-> ##2 rmw_read
    ##1 (rmw_write and mem.wdata[s_q.ins.bp]) ##2 done)
    else $error("bit set did not write a one");
  bit_clr_a: assert property (go && instr.op == OP_BIT_CLR |-> ##3
    rmw_write ##0 !mem.wdata[s_q.ins.bp] ##0 $stable(ps[6:0]))
    else $error("bit clear wrong or flags changed");
  branch_len_a: assert property (done && branch |->
    $past(s_q.tot) == CYC_BR_TAKEN || $past(s_q.tot) == CYC_TSB_TAKEN)
    else $error("taken branch has wrong length");
  prefix_end_a: assert property (done && s_q.ins.op < OP_PFX_ADB |->
    access_space == SPACE_DEF && !common_bank_sel)
    else $error("prefix effect outlived its instruction");
  check_on_a: assert property (go && instr.op == OP_CHECK_ON |-> ##2
    stack_check_en ##1 done)
    else $error("stack check enable failed");

  function automatic logic ccr_match(input logic [6:0] a, input logic [6:0] b);
    return a == b;
  endfunction

endmodule

/* File: src/ccb_lowbit.sv */
`timescale 1ns/1ps
// Finds the lowest set bit of a vector; scanning downward lets the lowest win.
module ccb_lowbit #(
  parameter int W = 8,
  parameter int IW = 3
) (
  input wire logic [W-1:0] vec,
  output logic [IW-1:0] idx,
  output logic any
);
  always_comb begin
    idx = '0;
    any = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = IW'(i);
        any = 1'b1;
      end
    end
  end
endmodule

/* File: testbench/test_cpu_control_and_bit_instructions.sv */
`timescale 1ns/1ps
module test_cpu_control_and_bit_instructions;
  import ccb_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  ccb_instr_t instr = '0;
  logic [15:0] ea = 16'h1234;
  logic [7:0] bank_rdata = 8'h3c;
  logic [15:0] rw_rdata = 16'h0000;
  logic [15:0] mem_rdata = 16'h0000;
  logic busy, done, branch, check_en, fault, common_bank_prefix;
  ccb_mem_t mem;
  ccb_rw_t rw;
  logic [31:0] acc;
  logic [15:0] sp, ps, lim_up, lim_lo;
  logic [2:0] space;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  logic [15:0] wdat;
  logic br_seen, cmr_seen;
  logic [2:0] spc_seen;
  ccb_op_t pfx[4] = '{OP_PFX_ADB, OP_PFX_DTB, OP_PFX_PCB, OP_PFX_SPB};
  ccb_op_t scan[3] = '{OP_SCAN, OP_SCAN_X2, OP_SCAN_X4};

  ccb_exec u_dut (.ref_clk(ref_clk), .rst(rst), .start(start), .instr(instr), .ea(ea),
    .bank_rdata(bank_rdata), .rw_rdata(rw_rdata), .mem_rdata(mem_rdata), .busy(busy),
    .done(done), .branch(branch), .mem(mem), .rw(rw), .acc(acc), .sp(sp), .ps(ps),
    .stack_limit_upper(lim_up), .stack_limit_lower(lim_lo), .stack_check_en(check_en),
    .stack_fault(fault), .access_space(space), .common_bank_sel(common_bank_prefix));

  // Free-running core clock, 25 ns period.
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // A hang is cut short well beyond the few hundred cycles the tests need.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Issues one instruction, counts busy cycles up to done and notes what the
  // block did meanwhile; a zero count means the length is not fixed.
  task automatic run(input ccb_op_t op, input logic [15:0] imm, input logic [2:0] bp,
                     input int cyc);
    @(negedge ref_clk);
    instr.op = op;
    instr.imm = imm;
    instr.bp = bp;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    n = 0;
    wdat = 16'hdead;
    spc_seen = space;
    cmr_seen = common_bank_prefix;
    while (done !== 1'b1 && n < 200) begin
      if (mem.req === 1'b1 && mem.we === 1'b1) wdat = mem.wdata;
      n++;
      @(negedge ref_clk);
    end
    br_seen = branch;
    if (cyc > 0) check(n, cyc);
  endtask

  // Main sequence: the instruction groups in turn, each with its expected state.
  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    check(sp, 16'h0000);
    mem_rdata = 16'h0050;
    run(OP_POP_A, 0, 0, 3);
    check({acc[15:0], sp}, {16'h0050, 16'h0002});
    run(OP_PUSH_A, 0, 0, 3);
    check({wdat, sp}, {16'h0050, 16'h0000});
    mem_rdata = 16'h00a5;
    run(OP_POP_AH, 0, 0, 3);
    run(OP_PUSH_AH, 0, 0, 3);
    check(acc, 32'h00a50050);
    check({wdat, sp}, {16'h00a5, 16'h0000});
    instr.list = 8'h03;
    run(OP_PUSH_LIST, 0, 0, 11);
    check({rw.idx, sp}, {3'h1, 16'hfffc});
    run(OP_POP_LIST, 0, 0, 11);
    check(sp, 16'h0000);
    check({rw.idx, rw.wdata}, {3'h0, 16'h00a5});
    mem_rdata = 16'h2b55;
    run(OP_POP_PS, 0, 0, 3);
    check({ps, sp}, {16'h2b55, 16'h0002});
    run(OP_AND_CCR, 16'h000f, 0, 3);
    check(ps[7:0], 8'h05);
    run(OP_OR_CCR, 16'h0060, 0, 3);
    check(ps[7:0], 8'h65);
    run(OP_MOV_RP, 16'h001f, 0, 2);
    run(OP_MOV_ILM, 16'h0005, 0, 2);
    check(ps, 16'hbf65);
    run(OP_PUSH_PS, 0, 0, 3);
    check({wdat, sp}, {16'hbf65, 16'h0000});
    run(OP_EFFECTIVE_ADDRESS_MOVE_A, 0, 0, 1);
    check({acc[15:0], ps[7:0]}, {16'h1234, 8'h65});
    instr.ridx = 3'h5;
    instr.ea_reg = 1'b1;
    run(OP_EFFECTIVE_ADDRESS_MOVE_RW, 0, 0, 3);
    check({rw.idx, rw.wdata}, {3'h5, 16'h1234});
    for (int b = 0; b < 7; b++) begin
      instr.bank = ccb_bank_t'(b);
      run(OP_MOV_A_BANK, 0, 0, (b < 5) ? 1 : b - 3);
    end
    check(acc[15:0], 16'h003c);
    for (int p = 0; p < 4; p++) begin
      run(pfx[p], 0, 0, 1);
      run(OP_MOV_RP, 16'h001f, 0, 2);
      check({spc_seen, space}, {3'(p + 1), 3'h0});
    end
    run(OP_PFX_CMR, 0, 0, 1);
    run(OP_MOV_RP, 16'h001f, 0, 2);
    check({cmr_seen, common_bank_prefix}, 2'b10);
    mem_rdata = 16'h0008;
    run(OP_PFX_NCC, 0, 0, 1);
    run(OP_BIT_TO_A, 0, 3, 3);
    check({acc[15:0], ps[3:2]}, {16'h00ff, 2'b00});
    run(OP_BIT_TO_A, 0, 3, 3);
    check(ps[3:2], 2'b10);
    run(OP_LIM_UPPER, 16'h1000, 0, 2);
    run(OP_LIM_LOWER, 16'h0100, 0, 2);
    check({lim_up, lim_lo}, 32'h10000100);
    run(OP_CHECK_ON, 0, 0, 2);
    @(negedge ref_clk);
    check({check_en, fault}, 2'b11);
    run(OP_CHECK_OFF, 0, 0, 2);
    check(check_en, 1'b0);
    for (int k = 0; k < 3; k++) begin
      mem_rdata = 16'h0050;
      run(OP_POP_A, 0, 0, 3);
      run(scan[k], 0, 0, 5 + k);
      check(acc[15:0], 16'h0004 << k);
    end
    mem_rdata = 16'h0000;
    run(OP_POP_A, 0, 0, 3);
    run(OP_SCAN_X4, 0, 0, 5);
    run(OP_BIT_SET, 0, 3, 4);
    check(wdat[7:0], 8'h08);
    mem_rdata = 16'h00ff;
    run(OP_BIT_CLR, 0, 3, 4);
    check(wdat[7:0], 8'hf7);
    run(OP_A_TO_BIT, 0, 3, 4);
    check(wdat[7:0], 8'hf7);
    mem_rdata = 16'h0000;
    run(OP_BR_CLEAR, 0, 3, 5);
    check(br_seen, 1'b1);
    run(OP_BR_SET, 0, 3, 4);
    check({br_seen, ps[CCR_Z]}, 2'b01);
    run(OP_TEST_SET_BR, 0, 3, 6);
    check({br_seen, wdat[7:0]}, 9'h008);
    mem_rdata = 16'h0008;
    run(OP_TEST_SET_BR, 0, 3, 7);
    check({br_seen, wdat[7:0]}, 9'h108);
    mem_rdata = 16'h0000;
    fork
      begin
        repeat (6) @(negedge ref_clk);
        mem_rdata = 16'h0001;
      end
    join_none
    run(OP_WAIT_HIGH, 0, 0, 0);
    check(n >= 5 && n < 200, 1'b1);
    fork
      begin
        repeat (6) @(negedge ref_clk);
        mem_rdata = 16'h0000;
      end
    join_none
    run(OP_WAIT_LOW, 0, 0, 0);
    check(n >= 5 && n < 200, 1'b1);
    summarize();
  end
endmodule
